/* logic/i2c_ctl_pkg.sv */
// Shared constants and types for the bus interface control register block
package i2c_ctl_pkg;
  // Byte offsets of the word registers on the register bus
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_MASK = 5'h08;
  localparam logic [4:0] OFF_SADDR = 5'h0c;
  localparam logic [4:0] OFF_SADDR2 = 5'h10;
  localparam logic [4:0] OFF_MODE = 5'h14;
  localparam logic [4:0] OFF_DATA = 5'h18;
  // Control register field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_MST = 5;
  localparam int BIT_TRS = 4;
  localparam int BIT_ACK_DECISION_ENABLE = 3;
  // Status register field positions
  localparam int EV_ARB = 0;
  localparam int EV_MATCH = 1;
  localparam int EV_DONE = 2;
  localparam int BIT_RECEIVED_ACK_STATUS = 3;
  localparam int NUM_EV = 3;
  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Operating modes chosen by the master and transmit select pair
  typedef enum logic [1:0] {
    SLV_RX = 2'b00,
    SLV_TX = 2'b01,
    MST_RX = 2'b10,
    MST_TX = 2'b11
  } op_mode_t;
endpackage

/* logic/mode_bits_if.sv */
// Carrier between the register front end and the mode bit keeper
`timescale 1ns/1ps
interface mode_bits_if;
  logic sw_wr;
  logic sw_rd;
  logic [1:0] wdata;
  logic arb_lost;
  logic match;
  logic rw_bit;
  logic busy;
  logic done;
  logic init;
  logic master_select;
  logic transmit_select;
  logic pend;
  modport owner (input sw_wr, sw_rd, wdata, arb_lost, match, rw_bit, busy, done, init,
    output master_select, transmit_select, pend);
  modport user (output sw_wr, sw_rd, wdata, arb_lost, match, rw_bit, busy, done, init,
    input master_select, transmit_select, pend);
endinterface

/* logic/mode_bits.sv */
// Master select and transmit select bits with their hardware updates
`timescale 1ns/1ps
module mode_bits
  import i2c_ctl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  mode_bits_if.owner mb
);
  logic mst_reg, trs_reg, mlock_reg, tlock_reg, hlock_reg, seen0m_reg, seen0t_reg, seen1t_reg;
  logic pend_reg, pval_reg;

  // Hardware events; arbitration loss wins over everything
  wire hw_clr = mb.arb_lost & mst_reg;
  wire hw_set = mb.match & ~mst_reg & ~trs_reg & mb.rw_bit & ~hw_clr;
  // Software writes permitted after a hardware change only past a confirming read
  wire m_ok = ~mlock_reg | seen0m_reg;
  wire t_ok = mb.wdata[0] ? (~tlock_reg | seen0t_reg) : (~hlock_reg | seen1t_reg);
  wire m_wr1 = mb.sw_wr & mb.wdata[1] & m_ok;
  wire t_wr = mb.sw_wr & t_ok;
  // Direction change waits for the running transfer to finish
  wire t_now = t_wr & ~mb.busy;
  wire t_defer = t_wr & mb.busy;
  wire p_apply = pend_reg & mb.done & ~mb.busy;

  wire mst_next = hw_clr ? 1'b0 : m_wr1 ? 1'b1 : (mb.sw_wr & ~mb.wdata[1]) ? 1'b0 : mst_reg;
  wire trs_next = hw_clr ? 1'b0 : hw_set ? 1'b1 : t_now ? mb.wdata[0] :
    p_apply ? pval_reg : trs_reg;
  wire mlock_next = hw_clr | (mlock_reg & ~m_wr1);
  wire tlock_next = hw_clr | (tlock_reg & ~(t_wr & mb.wdata[0]));
  wire hlock_next = ~hw_clr & (hw_set | (hlock_reg & ~(t_wr & ~mb.wdata[0])));
  wire seen0m_next = mlock_next & ~hw_clr & (seen0m_reg | (mb.sw_rd & ~mst_reg));
  wire seen0t_next = tlock_next & ~hw_clr & (seen0t_reg | (mb.sw_rd & ~trs_reg));
  wire seen1t_next = hlock_next & ~hw_set & (seen1t_reg | (mb.sw_rd & trs_reg));
  wire pend_next = ~hw_clr & ~p_apply & (pend_reg | t_defer);

  // Mode bits hold through a disable; only the tracking state is initialised
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mst_reg <= 1'b0;
      trs_reg <= 1'b0;
    end else begin
      mst_reg <= mst_next;
      trs_reg <= trs_next;
    end
  end

  // Locks, confirming reads and the deferred direction
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || mb.init) begin
      {mlock_reg, tlock_reg, hlock_reg} <= 3'h0;
      {seen0m_reg, seen0t_reg, seen1t_reg} <= 3'h0;
      pend_reg <= 1'b0;
      pval_reg <= 1'b0;
    end else begin
      {mlock_reg, tlock_reg, hlock_reg} <= {mlock_next, tlock_next, hlock_next};
      {seen0m_reg, seen0t_reg, seen1t_reg} <= {seen0m_next, seen0t_next, seen1t_next};
      pend_reg <= pend_next;
      pval_reg <= t_defer ? mb.wdata[0] : pval_reg;
    end
  end

  assign mb.master_select = mst_reg;
  assign mb.transmit_select = trs_reg;
  assign mb.pend = pend_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_relock_mst;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    mlock_reg && !seen0m_reg && mb.sw_wr && mb.wdata[1] && !mb.arb_lost && !mb.init
      |=> !mst_reg;
  endproperty
  a_relock_mst: assert property (p_relock_mst) else $error("master select set without read");

  property p_hwset_hold;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    hlock_reg && !seen1t_reg && trs_reg && !pend_reg && mb.sw_wr && !mb.wdata[0] &&
      !mb.arb_lost && !mb.init |=> trs_reg;
  endproperty
  a_hwset_hold: assert property (p_hwset_hold) else $error("transmit select cleared early");
endmodule

/* logic/i2c_control_regs.sv */
// Control register block of the two-wire bus interface with its register bus slave
//
// Overview of operation
// - Enable at 0 halts the interface, initialises state; slave addresses stay reachable.
// - Enable at 1 connects the pins, lets the bus be driven, opens mode and data.
// - Interrupt enable gates interface requests to the CPU; 0 blocks, 1 passes.
// - Master and transmit select pick slave rx, slave tx, master rx, master tx.
// - Arbitration loss as master clears both master and transmit select.
// - In slave receive, address match with read bit 1 sets transmit select.
// - Transmit select written during a transfer takes effect once it completes.
// - Master select follows writes; after arbitration loss, set only after reading 0.
// - Hardware set transmit select clears after reading 1; after loss, set after reading 0.
// - Acknowledge decision 0 ignores received acknowledge; acknowledge status reads 0.
// - Acknowledge decision 1 stops continuous transfer on a received acknowledge of 1.
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module i2c_control_regs
  import i2c_ctl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic eng_arb_lost_in,
  input wire logic eng_addr_match_in,
  input wire logic eng_rw_bit_in,
  input wire logic eng_busy_in,
  input wire logic eng_done_in,
  input wire logic eng_ack_valid_in,
  input wire logic eng_rx_ack_in,
  input wire logic eng_scl_low_in,
  input wire logic eng_sda_low_in,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic scl_sync_out,
  output logic sda_sync_out,
  output logic engine_run_out,
  output logic engine_init_out,
  output logic [1:0] op_mode_out,
  output logic ack_decision_out,
  output logic stop_xfer_out,
  output logic [7:0] slave_addr_out,
  output logic [7:0] second_slave_addr_out,
  output logic [7:0] mode_out,
  output logic [7:0] tx_data_out,
  output logic irq_out
);
  mode_bits_if mb ();

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic enable_reg, irq_en_reg, ack_decision_enable_reg, received_ack_status_reg;
  logic [NUM_EV-1:0] stat_reg, mask_reg;
  logic [7:0] saddr_reg, saddr2_reg, mode_reg, data_reg;
  logic scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
  logic scl_oe_reg, sda_oe_reg, stop_reg, irq_reg, init_reg, run_reg;
  logic [1:0] op_mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  // One wait cycle per request; the request is taken when waitrequest is seen low
  wire req = avs_read_in | avs_write_in;
  wire accept = req & ~wait_reg;
  wire first = req & wait_reg;
  wire wr = accept & avs_write_in & avs_byteenable_in[0];
  wire rd = accept & avs_read_in;

  // Mode and data registers are only reachable while the interface is enabled
  wire hit_ctrl = avs_address_in == OFF_CTRL;
  wire hit_stat = avs_address_in == OFF_STAT;
  wire hit_mask = avs_address_in == OFF_MASK;
  wire hit_sa = avs_address_in == OFF_SADDR;
  wire hit_sa2 = avs_address_in == OFF_SADDR2;
  wire hit_mode = (avs_address_in == OFF_MODE) & enable_reg;
  wire hit_data = (avs_address_in == OFF_DATA) & enable_reg;
  wire [7:0] wbyte = avs_writedata_in[7:0];

  // Control read image; reserved bits read as zero
  wire [7:0] ctrl_img = {enable_reg, irq_en_reg, mb.master_select, mb.transmit_select, ack_decision_enable_reg, 3'h0};
  wire [7:0] stat_img = {4'h0, received_ack_status_reg, stat_reg};

  // Read multiplexer; unmapped or closed addresses read as zero
  wire [7:0] rbyte = hit_ctrl ? ctrl_img :
    hit_stat ? stat_img :
    hit_mask ? {5'h00, mask_reg} :
    hit_sa ? saddr_reg :
    hit_sa2 ? saddr2_reg :
    hit_mode ? mode_reg :
    hit_data ? data_reg : BYTE_RST;

  // Waitrequest drops for exactly one cycle after a new request appears
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~first;
    end
  end

  // Read data is captured one edge early so it stands at the taking edge
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (first && avs_read_in) begin
      rdata_reg <= {24'h00_0000, rbyte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields kept here

  wire ctrl_wr = wr & hit_ctrl;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      {enable_reg, irq_en_reg} <= CTRL_RST[7:6];
      ack_decision_enable_reg <= CTRL_RST[BIT_ACK_DECISION_ENABLE];
    end else if (ctrl_wr) begin
      enable_reg <= wbyte[BIT_ENABLE];
      irq_en_reg <= wbyte[BIT_IRQ_EN];
      ack_decision_enable_reg <= wbyte[BIT_ACK_DECISION_ENABLE];
    end
  end

  // Address, mode and data storage
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      {saddr_reg, saddr2_reg} <= {BYTE_RST, BYTE_RST};
      {mode_reg, data_reg} <= {BYTE_RST, BYTE_RST};
    end else begin
      saddr_reg <= (wr && hit_sa) ? wbyte : saddr_reg;
      saddr2_reg <= (wr && hit_sa2) ? wbyte : saddr2_reg;
      mode_reg <= (wr && hit_mode) ? wbyte : mode_reg;
      data_reg <= (wr && hit_data) ? wbyte : data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode bits, shared with the keeper module

  // Engine events count only while the interface runs; a disable drops them
  assign mb.sw_wr = ctrl_wr;
  assign mb.sw_rd = rd & hit_ctrl;
  assign mb.wdata = {wbyte[BIT_MST], wbyte[BIT_TRS]};
  assign mb.arb_lost = eng_arb_lost_in & enable_reg;
  assign mb.match = eng_addr_match_in & enable_reg;
  assign mb.rw_bit = eng_rw_bit_in;
  assign mb.busy = eng_busy_in & enable_reg;
  assign mb.done = eng_done_in & enable_reg;
  assign mb.init = ~enable_reg;

  mode_bits u_mode_bits (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .mb(mb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Events, acknowledge status and the interrupt

  wire [NUM_EV-1:0] events = {mb.done, mb.match, mb.arb_lost & mb.master_select};
  // Only the bits a read actually returned are cleared; a new event wins
  wire [NUM_EV-1:0] rd_clr = (rd && hit_stat) ? rdata_reg[NUM_EV-1:0] : '0;
  wire [NUM_EV-1:0] stat_next = (stat_reg & ~rd_clr) | events;
  // Acknowledge ignored and status forced low while the decision is off
  wire received_ack_status_next = ~ack_decision_enable_reg ? 1'b0 : (eng_ack_valid_in & enable_reg) ? eng_rx_ack_in :
    received_ack_status_reg;
  wire stop_next = eng_ack_valid_in & enable_reg & ack_decision_enable_reg & eng_rx_ack_in;
  wire irq_next = irq_en_reg & |(stat_reg & mask_reg);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      stat_reg <= '0;
      mask_reg <= MASK_RST;
      received_ack_status_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= (wr && hit_mask) ? wbyte[NUM_EV-1:0] : mask_reg;
      received_ack_status_reg <= received_ack_status_next;
    end
  end

  // Stop pulse and interrupt level
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      stop_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      stop_reg <= stop_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and engine controls

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      {scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg} <= 4'hf;
    end else begin
      {scl_m_reg, sda_m_reg} <= {scl_pin_in, sda_pin_in};
      {scl_s_reg, sda_s_reg} <= {scl_m_reg, sda_m_reg};
    end
  end

  // Open-drain drive only while enabled; a disabled block releases the bus
  // Init keeps its own flop so that the output leaves a register, not an inverter
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      {scl_oe_reg, sda_oe_reg} <= 2'h0;
      init_reg <= 1'b1;
      run_reg <= 1'b0;
      op_mode_reg <= SLV_RX;
    end else begin
      scl_oe_reg <= enable_reg & eng_scl_low_in;
      sda_oe_reg <= enable_reg & eng_sda_low_in;
      init_reg <= ~enable_reg;
      run_reg <= enable_reg;
      op_mode_reg <= {mb.master_select, mb.transmit_select};
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign avs_waitrequest_out = wait_reg;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;
  assign scl_sync_out = scl_s_reg;
  assign sda_sync_out = sda_s_reg;
  assign engine_run_out = run_reg;
  assign engine_init_out = init_reg;
  assign op_mode_out = op_mode_reg;
  assign ack_decision_out = ack_decision_enable_reg;
  assign stop_xfer_out = stop_reg;
  assign slave_addr_out = saddr_reg;
  assign second_slave_addr_out = saddr2_reg;
  assign mode_out = mode_reg;
  assign tx_data_out = data_reg;
  assign irq_out = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_off_release;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !enable_reg |=> !scl_oe_out && !sda_oe_out && engine_init_out;
  endproperty
  a_off_release: assert property (p_off_release) else $error("bus driven while off");

  property p_on_drive;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    enable_reg && eng_sda_low_in |=> sda_oe_out;
  endproperty
  a_on_drive: assert property (p_on_drive) else $error("enabled block not driving");

  property p_irq_gate;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    irq_out |-> $past(irq_en_reg) && $past(|(stat_reg & mask_reg));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

  property p_mode_mt;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (ctrl_wr && wbyte[5:4] == 2'b11 && !eng_busy_in && !mb.arb_lost && !mb.match)
      ##1 (mb.master_select && mb.transmit_select) |=> op_mode_out == MST_TX;
  endproperty
  a_mode_mt: assert property (p_mode_mt) else $error("mode not master transmit");

  property p_arb_clear;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    mb.arb_lost && mb.master_select |=> !mb.master_select && !mb.transmit_select ##1 op_mode_out == SLV_RX;
  endproperty
  a_arb_clear: assert property (p_arb_clear) else $error("arbitration loss not cleared");

  property p_match_tx;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    mb.match && !mb.master_select && !mb.transmit_select && eng_rw_bit_in && !mb.arb_lost |=> mb.transmit_select;
  endproperty
  a_match_tx: assert property (p_match_tx) else $error("address match left receive");

  property p_defer;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ctrl_wr && mb.busy && !mb.match && !mb.arb_lost && !mb.done |=> $stable(mb.transmit_select);
  endproperty
  a_defer: assert property (p_defer) else $error("direction changed mid transfer");

  property p_received_ack_status_zero;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !ack_decision_enable_reg |=> !received_ack_status_reg && !stop_xfer_out;
  endproperty
  a_received_ack_status_zero: assert property (p_received_ack_status_zero) else $error("acknowledge not ignored");

  property p_ack_stop;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    eng_ack_valid_in && eng_rx_ack_in && ack_decision_enable_reg && enable_reg |=> stop_xfer_out && received_ack_status_reg;
  endproperty
  a_ack_stop: assert property (p_ack_stop) else $error("no stop on negative acknowledge");

  // Engine controls, interrupt gate, acknowledge capture and the pending direction
  property p_run_follow;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    enable_reg |=> engine_run_out && !engine_init_out;
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("engine not released");

  property p_irq_block;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !irq_en_reg |=> !irq_out;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("irq passed while blocked");

  property p_received_ack_status_capture;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ack_decision_enable_reg && enable_reg && eng_ack_valid_in |=> received_ack_status_reg == $past(eng_rx_ack_in);
  endproperty
  a_received_ack_status_capture: assert property (p_received_ack_status_capture) else $error("ack status not taken");

  property p_pend_apply;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    mb.pend && mb.done && !mb.busy |=> !mb.pend;
  endproperty
  a_pend_apply: assert property (p_pend_apply) else $error("direction not applied");

  property p_init_drop;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    mb.init |=> !mb.pend;
  endproperty
  a_init_drop: assert property (p_init_drop) else $error("pending kept while off");

  // Main scenarios the bench should reach
  c_arb: cover property (@(posedge sys_clk_in) mb.arb_lost && mb.master_select);
  c_match: cover property (@(posedge sys_clk_in) mb.match && eng_rw_bit_in && !mb.master_select);
  c_defer: cover property (@(posedge sys_clk_in) mb.pend ##[1:50] !mb.pend);
  c_irq: cover property (@(posedge sys_clk_in) $rose(irq_out));
endmodule

/* verif/bus_peer_model.sv */
// Far-side stand-in: bit engine events and the pulled-up open-drain lines
`timescale 1ns/1ps
module bus_peer_model (
  input wire logic sys_clk_in,
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic arb_lost_out,
  output logic match_out,
  output logic rw_bit_out,
  output logic busy_out,
  output logic done_out,
  output logic ack_valid_out,
  output logic rx_ack_out,
  output logic scl_low_out,
  output logic sda_low_out,
  output wire logic scl_pin_out,
  output wire logic sda_pin_out
);
  // Lines idle high through the pull-ups unless some party pulls them low
  assign scl_pin_out = !(scl_oe_in || scl_low_out);
  assign sda_pin_out = !(sda_oe_in || sda_low_out);
  // Quiet at time zero
  initial begin
    {arb_lost_out, match_out, rw_bit_out, busy_out, done_out} = 5'h00;
    {ack_valid_out, rx_ack_out, scl_low_out, sda_low_out} = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Arbitration loss lasts exactly one cycle
  task automatic arb_loss();
    @(posedge sys_clk_in);
    arb_lost_out <= 1'b1;
    @(posedge sys_clk_in);
    arb_lost_out <= 1'b0;
  endtask
  // Direction bit is only valid with the match; afterwards it is turned over
  task automatic addr_hit(input logic rw);
    @(posedge sys_clk_in);
    match_out <= 1'b1;
    rw_bit_out <= rw;
    @(posedge sys_clk_in);
    match_out <= 1'b0;
    rw_bit_out <= !rw;
  endtask
  task automatic ack_seen(input logic v);
    @(posedge sys_clk_in);
    ack_valid_out <= 1'b1;
    rx_ack_out <= v;
    @(posedge sys_clk_in);
    ack_valid_out <= 1'b0;
    rx_ack_out <= !v;
  endtask
  task automatic start_xfer();
    @(posedge sys_clk_in);
    busy_out <= 1'b1;
  endtask
  // Busy falls on the edge that reports completion
  task automatic end_xfer();
    @(posedge sys_clk_in);
    busy_out <= 1'b0;
    done_out <= 1'b1;
    @(posedge sys_clk_in);
    done_out <= 1'b0;
  endtask
  task automatic pull_low(input logic s, input logic d);
    @(posedge sys_clk_in);
    scl_low_out <= s;
    sda_low_out <= d;
  endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the control register block against its far-side peer
`timescale 1ns/1ps
module tb import i2c_ctl_pkg::*;;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out, r;
  logic avs_waitrequest_out, eng_arb_lost_in, eng_addr_match_in, eng_rw_bit_in, eng_busy_in;
  logic eng_done_in, eng_ack_valid_in, eng_rx_ack_in, eng_scl_low_in, eng_sda_low_in;
  logic scl_pin_in, sda_pin_in, scl_oe_out, sda_oe_out, engine_run_out, engine_init_out;
  logic ack_decision_out, stop_xfer_out, irq_out, scl_out, sda_out, scl_sync_out, sda_sync_out;
  logic [1:0] op_mode_out;
  logic [7:0] slave_addr_out, mode_out, second_slave_addr_out, tx_data_out;
  int fails = 0;
  int samples_checked = 0;
  // 200 MHz clock
  always #2.5 sys_clk_in = ~sys_clk_in;
  i2c_control_regs uut (.sys_clk_in, .sys_rst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .eng_arb_lost_in, .eng_addr_match_in, .eng_rw_bit_in, .eng_busy_in,
    .eng_done_in, .eng_ack_valid_in, .eng_rx_ack_in, .eng_scl_low_in, .eng_sda_low_in,
    .scl_pin_in, .sda_pin_in, .scl_out, .scl_oe_out, .sda_out, .sda_oe_out,
    .scl_sync_out, .sda_sync_out, .engine_run_out, .engine_init_out, .op_mode_out,
    .ack_decision_out, .stop_xfer_out, .slave_addr_out, .second_slave_addr_out, .mode_out,
    .tx_data_out, .irq_out);
  bus_peer_model peer (.sys_clk_in, .scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out),
    .arb_lost_out(eng_arb_lost_in), .match_out(eng_addr_match_in), .rw_bit_out(eng_rw_bit_in),
    .busy_out(eng_busy_in), .done_out(eng_done_in), .ack_valid_out(eng_ack_valid_in),
    .rx_ack_out(eng_rx_ack_in), .scl_low_out(eng_scl_low_in), .sda_low_out(eng_sda_low_in),
    .scl_pin_out(scl_pin_in), .sda_pin_out(sda_pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Request held until the rising edge that sees waitrequest low; a hang is the watchdog's
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00, r);
    chk_word(r, e);
  endtask
  // Mode pins trail the bits by one cycle
  task automatic mode_is(input logic [1:0] m);
    repeat (2) @(negedge sys_clk_in);
    chk_word({30'h0, op_mode_out}, {30'h0, m});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_enable();
    chk_bit(avs_waitrequest_out, 1'b1);
    rd(OFF_CTRL, {24'h0, CTRL_RST});
    chk_bit(engine_init_out, 1'b1);
    wr(OFF_SADDR, 8'h5a);
    rd(OFF_SADDR, 32'h5a);
    chk_word({24'h0, slave_addr_out}, 32'h5a);
    wr(OFF_SADDR2, 8'h69);
    rd(OFF_SADDR2, 32'h69);
    chk_word({24'h0, second_slave_addr_out}, 32'h69);
    wr(OFF_MODE, 8'h3c);
    rd(OFF_MODE, 32'h0);
    chk_word({24'h0, mode_out}, 32'h0);
    peer.pull_low(1'b1, 1'b1);
    repeat (2) @(negedge sys_clk_in);
    chk_bit(scl_oe_out, 1'b0);
    wr(OFF_CTRL, 8'h80);
    repeat (2) @(negedge sys_clk_in);
    chk_bit(scl_oe_out, 1'b1);
    chk_bit(sda_oe_out, 1'b1);
    chk_bit(engine_run_out, 1'b1);
    chk_bit(scl_out | sda_out | scl_sync_out | sda_sync_out, 1'b0);
    peer.pull_low(1'b0, 1'b0);
    wr(OFF_MODE, 8'h3c);
    rd(OFF_MODE, 32'h3c);
    wr(OFF_DATA, 8'ha5);
    rd(OFF_DATA, 32'ha5);
    chk_word({16'h0, mode_out, tx_data_out}, 32'h3ca5);
    chk_bit(scl_sync_out & sda_sync_out, 1'b1);
    wr(5'h1c, 8'hff);
    rd(5'h1c, 32'h0);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 8'h80 | 8'(m << 4));
      mode_is(2'(m));
      rd(OFF_CTRL, 32'h80 | 32'(m << 4));
    end
  endtask
  task automatic t_arb();
    wr(OFF_CTRL, 8'hb0);
    peer.arb_loss();
    mode_is(2'b00);
    wr(OFF_CTRL, 8'hb0);
    mode_is(2'b00);
    rd(OFF_CTRL, 32'h80);
    wr(OFF_CTRL, 8'hb0);
    mode_is(2'b11);
    rd(OFF_STAT, 32'h1);
    rd(OFF_STAT, 32'h0);
  endtask
  task automatic t_match();
    wr(OFF_CTRL, 8'h80);
    peer.addr_hit(1'b0);
    mode_is(2'b00);
    peer.addr_hit(1'b1);
    mode_is(2'b01);
    wr(OFF_CTRL, 8'h80);
    mode_is(2'b01);
    rd(OFF_CTRL, 32'h90);
    wr(OFF_CTRL, 8'h80);
    mode_is(2'b00);
    rd(OFF_STAT, 32'h2);
  endtask
  task automatic t_defer();
    wr(OFF_CTRL, 8'ha0);
    peer.start_xfer();
    wr(OFF_CTRL, 8'hb0);
    mode_is(2'b10);
    peer.end_xfer();
    mode_is(2'b11);
    rd(OFF_STAT, 32'h4);
  endtask
  task automatic t_ack();
    wr(OFF_CTRL, 8'h80);
    peer.ack_seen(1'b1);
    @(negedge sys_clk_in);
    chk_bit(stop_xfer_out, 1'b0);
    rd(OFF_STAT, 32'h0);
    wr(OFF_CTRL, 8'h88);
    peer.ack_seen(1'b1);
    @(negedge sys_clk_in);
    chk_bit(stop_xfer_out, 1'b1);
    @(negedge sys_clk_in);
    chk_bit(stop_xfer_out, 1'b0);
    chk_bit(ack_decision_out, 1'b1);
    rd(OFF_STAT, 32'h8);
  endtask
  // Only the unmasked arbitration event may reach the request line
  task automatic t_irq();
    wr(OFF_MASK, 8'h01);
    wr(OFF_CTRL, 8'hb0);
    peer.arb_loss();
    repeat (2) @(negedge sys_clk_in);
    chk_bit(irq_out, 1'b0);
    wr(OFF_CTRL, 8'hc0);
    repeat (2) @(negedge sys_clk_in);
    chk_bit(irq_out, 1'b1);
    rd(OFF_STAT, 32'h1);
    repeat (2) @(negedge sys_clk_in);
    chk_bit(irq_out, 1'b0);
    peer.addr_hit(1'b0);
    repeat (2) @(negedge sys_clk_in);
    chk_bit(irq_out, 1'b0);
    rd(OFF_STAT, 32'h2);
    wr(OFF_CTRL, 8'h00);
    repeat (2) @(negedge sys_clk_in);
    chk_bit(engine_init_out, 1'b1);
    rd(OFF_MODE, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_enable();
    t_modes();
    t_arb();
    t_match();
    t_defer();
    t_ack();
    t_irq();
    report_and_stop();
  end
endmodule
